//--- fail_safe_monitor_pkg.sv
// Constants and types shared by the fail-safe clock monitor
package fail_safe_monitor_pkg;

  // Clock source encodings of the clock select register
  localparam logic [1:0] SEL_PRIMARY   = 2'h0;
  localparam logic [1:0] SEL_SECONDARY = 2'h1;
  localparam logic [1:0] SEL_INTERNAL  = 2'h2;

  // Primary oscillator modes
  localparam logic [2:0] ext_clock_mode          = 3'h0;
  localparam logic [2:0] resistor_cap_osc_mode   = 3'h1;
  localparam logic [2:0] internal_slow_osc_mode  = 3'h2;
  localparam logic [2:0] low_power_crystal_mode  = 3'h3;
  localparam logic [2:0] crystal_mode            = 3'h4;
  localparam logic [2:0] high_speed_crystal_mode = 3'h5;
  localparam logic [2:0] fast_crystal_pll_mode   = 3'h6;

  // System clock rate
  localparam int unsigned CLK_PERIOD_PS = 10000;

  // Internal slow oscillator period, modelled as a divided enable
  localparam int unsigned INT_SLOW_OSC_PERIOD_NS = 4000;
  localparam int unsigned INT_SLOW_OSC_CYCLES =
    (INT_SLOW_OSC_PERIOD_NS * 1000) / CLK_PERIOD_PS;

  // Sample clock is the internal slow oscillator divided by 64
  localparam int unsigned SAMPLE_DIV      = 64;
  localparam int unsigned SAMPLE_DIV_HALF = SAMPLE_DIV / 2;

  // Start-up timer lengths (primary edges, slow oscillator ticks)
  localparam int unsigned STARTUP_EDGES = 1024;
  localparam int unsigned PLL_TICKS = 64;

  // Source actually driving the device clock
  typedef enum logic [1:0] {
    SRC_PRIMARY,
    SRC_SECONDARY,
    SRC_INTERNAL
  } clk_src_t;

  // Start-up sequencer
  typedef enum logic [1:0] {
    ST_RUN,
    ST_XTAL_WAIT,
    ST_PLL_WAIT,
    ST_ASLEEP
  } startup_t;

endpackage : fail_safe_monitor_pkg

//--- fail_safe_monitor.sv
// Fail-safe clock monitor with start-up bridging and glitch-free clock mux
// Behaviour
// - Entering a power-managed mode applies the source in the clock select register.
// - Monitoring of the mode's clock source continues inside power-managed modes.
// - Failure with interrupt enabled keeps execution running on the internal oscillator.
// - A failed source is never reselected automatically, only by explicit change.
// - Failure interrupt disabled and Idle: later interrupts resume on internal oscillator.
// - External, RC and internal RC primary modes are monitored right after reset/wake.
// - Crystal modes run on internal oscillator until the start-up timer expires, then the PLL timer in PLL mode.
// - When primary is stable, switch to it; slow oscillator only feeds the monitor and the PLL timer.
// - A primary that never starts during bridging is never flagged as failed.
// - Selecting another power-managed mode while stabilising disables the primary clock.
// - Sample clock is the internal slow oscillator divided by 64.
// - Latch sets on device clock falling edge, clears on sample clock rising edge.
// - Latch set at sample falling edge: flag, switch internal, keep select, reset watchdog.
// - Fail-safe ends only on device reset or power-managed mode entry.
`timescale 1ns/10ps
`default_nettype none

module fail_safe_monitor
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       pri_osc_in,
  input  wire logic       sec_osc_in,
  input  wire logic       internal_osc_block_in,
  input  wire logic [2:0] primary_mode,
  input  wire logic [1:0] clock_select_register,
  input  wire logic       monitor_enable_bit,
  input  wire logic       osc_fail_ie,
  input  wire logic       osc_fail_flag_clr,
  input  wire logic       pm_enter,
  input  wire logic       sleep_enter,
  input  wire logic       wake,
  input  wire logic       idle_mode,
  input  wire logic       irq_pending,
  output logic            dev_clk_out,
  output logic [1:0]      active_src,
  output logic            primary_osc_enable,
  output logic            primary_clock_ready_status,
  output logic            osc_fail_flag,
  output logic            fail_safe_active,
  output logic            wdt_reset,
  output logic            cpu_resume
);

  // Synchronised copies of the oscillator pins, two clk cycles late
  logic [2:0]           sync_a;
  logic [2:0]           sync_b;
  logic [2:0]           sync_prev;
  logic                 pri_s;
  logic                 sec_s;
  logic                 int_s;
  logic                 pri_fall;

  // Slow oscillator divider and sample clock
  logic [15:0]          slow_cnt;
  logic                 slow_tick;
  logic [5:0]           sample_cnt;
  logic                 sample_clk;
  logic                 sample_rise;
  logic                 sample_fall;

  // Monitor and sequencer state
  logic                 clock_monitor_latch;
  logic                 monitored_fall;
  logic                 monitor_on;
  logic                 fail_detect;
  fail_safe_monitor_pkg::startup_t   state;
  fail_safe_monitor_pkg::startup_t   next_state;
  logic [10:0]          crystal_startup_timer;
  logic [7:0]           pll_timer;
  logic [1:0]           applied_sel;
  fail_safe_monitor_pkg::clk_src_t   target_src;
  fail_safe_monitor_pkg::clk_src_t   cur_src;
  logic                 target_lvl;
  logic                 cur_lvl;
  logic                 power_on;

  // True for oscillator modes that need a crystal start-up period
  function automatic logic is_crystal(input logic [2:0] mode);
    is_crystal = (mode == fail_safe_monitor_pkg::low_power_crystal_mode) ||
                 (mode == fail_safe_monitor_pkg::crystal_mode) ||
                 (mode == fail_safe_monitor_pkg::high_speed_crystal_mode) ||
                 (mode == fail_safe_monitor_pkg::fast_crystal_pll_mode);
  endfunction : is_crystal

  // Level of a given source, taken from the synchronised pins
  function automatic logic src_level(input fail_safe_monitor_pkg::clk_src_t src,
                                     input logic p, input logic s, input logic i);
    case (src)
      fail_safe_monitor_pkg::SRC_PRIMARY:   src_level = p;
      fail_safe_monitor_pkg::SRC_SECONDARY: src_level = s;
      default:                 src_level = i;
    endcase
  endfunction : src_level

  // Two-flop synchronisers; logic looks at sync_b and at its one-cycle-delayed copy sync_prev
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync_a    <= 3'h0;
      sync_b    <= 3'h0;
      sync_prev <= 3'h0;
    end
    else
    begin
      sync_a    <= {internal_osc_block_in, sec_osc_in, pri_osc_in};
      sync_b    <= sync_a;
      sync_prev <= sync_b;
    end
  end

  assign pri_s    = sync_b[0];
  assign sec_s    = sync_b[1];
  assign int_s    = sync_b[2];
  assign pri_fall = sync_prev[0] & ~sync_b[0];

  // Internal slow oscillator tick from a clk divider
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      slow_cnt <= 16'h0000;
    else if (slow_tick)
      slow_cnt <= 16'h0000;
    else
      slow_cnt <= slow_cnt + 16'h0001;
  end

  assign slow_tick = (slow_cnt == 16'(fail_safe_monitor_pkg::INT_SLOW_OSC_CYCLES - 1));

  // Divide by 64: high for the first half, low for the second
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sample_cnt <= 6'h00;
      sample_clk <= 1'b0;
    end
    else if (slow_tick)
    begin
      sample_cnt <= sample_cnt + 6'h01;
      sample_clk <= (sample_cnt + 6'h01) < 6'(fail_safe_monitor_pkg::SAMPLE_DIV_HALF);
    end
  end

  assign sample_rise = slow_tick && (sample_cnt == 6'(fail_safe_monitor_pkg::SAMPLE_DIV - 1));
  assign sample_fall = slow_tick && (sample_cnt == 6'(fail_safe_monitor_pkg::SAMPLE_DIV_HALF - 1));

  // Target source: the applied selection unless bridging, asleep or failed over
  always_comb
  begin
    if (fail_safe_active || state != fail_safe_monitor_pkg::ST_RUN)
      target_src = fail_safe_monitor_pkg::SRC_INTERNAL;
    else if (applied_sel == fail_safe_monitor_pkg::SEL_PRIMARY)
      target_src = fail_safe_monitor_pkg::SRC_PRIMARY;
    else if (applied_sel == fail_safe_monitor_pkg::SEL_SECONDARY)
      target_src = fail_safe_monitor_pkg::SRC_SECONDARY;
    else
      target_src = fail_safe_monitor_pkg::SRC_INTERNAL;
  end

  assign target_lvl = src_level(target_src, pri_s, sec_s, int_s);
  assign cur_lvl    = src_level(cur_src, pri_s, sec_s, int_s);

  // Switch only while both old and new sources are low, so no runt phase
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cur_src     <= fail_safe_monitor_pkg::SRC_INTERNAL;
      dev_clk_out <= 1'b0;
    end
    else
    begin
      if (cur_src != target_src && !cur_lvl && !target_lvl)
      begin
        cur_src     <= target_src;
        dev_clk_out <= 1'b0;
      end
      else
        dev_clk_out <= cur_lvl;
    end
  end

  assign active_src = cur_src;

  // Reset applies the primary source; clock select is applied on power-managed entry
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      applied_sel <= fail_safe_monitor_pkg::SEL_PRIMARY;
    else if (pm_enter)
      applied_sel <= clock_select_register;
  end

  // Monitor only an external source, running, not bridging, not asleep
  assign monitor_on = monitor_enable_bit && !fail_safe_active &&
                      state == fail_safe_monitor_pkg::ST_RUN &&
                      target_src != fail_safe_monitor_pkg::SRC_INTERNAL;
  assign monitored_fall = (target_src == fail_safe_monitor_pkg::SRC_PRIMARY) ? pri_fall :
                          (sync_prev[1] & ~sync_b[1]);
  assign fail_detect = monitor_on && sample_fall && clock_monitor_latch;

  // Latch: set by monitored falling edge, cleared by sample rising edge
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      clock_monitor_latch <= 1'b0;
    else if (!monitor_on)
      clock_monitor_latch <= 1'b0;
    else if (sample_rise)
      clock_monitor_latch <= 1'b0;
    else if (monitored_fall)
      clock_monitor_latch <= 1'b1;
  end

  // Fail-safe condition holds until reset or power-managed entry
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      fail_safe_active <= 1'b0;
    else if (fail_detect)
      fail_safe_active <= 1'b1;
    else if (pm_enter)
      fail_safe_active <= 1'b0;
  end

  // Sticky flag; a new failure wins over a clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      osc_fail_flag <= 1'b0;
    else if (fail_detect)
      osc_fail_flag <= 1'b1;
    else if (osc_fail_flag_clr)
      osc_fail_flag <= 1'b0;
  end

  // Watchdog restart on each failover
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      wdt_reset <= 1'b0;
    else
      wdt_reset <= fail_detect;
  end

  // Idle wake on interrupt once failed over, or whenever the failure interrupt is disabled
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cpu_resume <= 1'b0;
    else
      cpu_resume <= idle_mode && irq_pending &&
                    (fail_safe_active || !osc_fail_ie);
  end

  // Start-up sequencer: crystal modes bridge on the internal block
  always_comb
  begin
    next_state = state;
    case (state)
      fail_safe_monitor_pkg::ST_RUN:
        if (sleep_enter)
          next_state = fail_safe_monitor_pkg::ST_ASLEEP;
      fail_safe_monitor_pkg::ST_ASLEEP:
        if (wake || power_on)
          next_state = is_crystal(primary_mode) ? fail_safe_monitor_pkg::ST_XTAL_WAIT
                                                : fail_safe_monitor_pkg::ST_RUN;
      fail_safe_monitor_pkg::ST_XTAL_WAIT:
        if (pm_enter && clock_select_register != fail_safe_monitor_pkg::SEL_PRIMARY)
          next_state = fail_safe_monitor_pkg::ST_RUN;
        else if (pri_fall &&
                 crystal_startup_timer == 11'(fail_safe_monitor_pkg::STARTUP_EDGES - 1))
          next_state = (primary_mode == fail_safe_monitor_pkg::fast_crystal_pll_mode)
                       ? fail_safe_monitor_pkg::ST_PLL_WAIT : fail_safe_monitor_pkg::ST_RUN;
      fail_safe_monitor_pkg::ST_PLL_WAIT:
        if (pm_enter && clock_select_register != fail_safe_monitor_pkg::SEL_PRIMARY)
          next_state = fail_safe_monitor_pkg::ST_RUN;
        else if (slow_tick && pll_timer == 8'(fail_safe_monitor_pkg::PLL_TICKS - 1))
          next_state = fail_safe_monitor_pkg::ST_RUN;
      default:
        next_state = fail_safe_monitor_pkg::ST_RUN;
    endcase
  end

  // Power-on flag: first edge after reset acts as a wake, later sleeps last
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      power_on <= 1'b1;
    else
      power_on <= 1'b0;
  end

  // Sequencer state
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state <= fail_safe_monitor_pkg::ST_ASLEEP;
    else
      state <= next_state;
  end

  // Start-up timers count only while their phase is active
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      crystal_startup_timer <= 11'h000;
      pll_timer             <= 8'h00;
    end
    else
    begin
      if (state != fail_safe_monitor_pkg::ST_XTAL_WAIT)
        crystal_startup_timer <= 11'h000;
      else if (pri_fall)
        crystal_startup_timer <= crystal_startup_timer + 11'h001;
      if (state != fail_safe_monitor_pkg::ST_PLL_WAIT)
        pll_timer <= 8'h00;
      else if (slow_tick)
        pll_timer <= pll_timer + 8'h01;
    end
  end

  // Ready status and primary oscillator enable
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      primary_clock_ready_status <= 1'b0;
      primary_osc_enable         <= 1'b1;
    end
    else
    begin
      if (sleep_enter)
        primary_osc_enable <= 1'b0;
      else if (state == fail_safe_monitor_pkg::ST_ASLEEP && wake)
        primary_osc_enable <= 1'b1;
      else if (state != fail_safe_monitor_pkg::ST_RUN && state != fail_safe_monitor_pkg::ST_ASLEEP &&
               next_state == fail_safe_monitor_pkg::ST_RUN &&
               pm_enter && clock_select_register != fail_safe_monitor_pkg::SEL_PRIMARY)
        primary_osc_enable <= 1'b0;
      else if (pm_enter && clock_select_register == fail_safe_monitor_pkg::SEL_PRIMARY)
        primary_osc_enable <= 1'b1;
      // Ready only once running with no bridging in progress
      primary_clock_ready_status <= (state == fail_safe_monitor_pkg::ST_RUN) &&
                                    primary_osc_enable &&
                                    cur_src == fail_safe_monitor_pkg::SRC_PRIMARY;
    end
  end

endmodule : fail_safe_monitor
`default_nettype wire

//--- osc_model.sv
// Behavioural oscillator source standing on the far side of the monitor
`timescale 1ns/10ps
`default_nettype none
module osc_model
#(
  parameter int HALF_NS = 40
)
(
  input  wire logic run,
  output logic      osc
);
  // A stopped or disabled crystal settles low instead of holding a phase
  initial osc = 1'b0;
  always
  begin
    #(HALF_NS);
    osc = run ? ~osc : 1'b0;
  end
endmodule : osc_model
`default_nettype wire

//--- fsm_properties.sv
// Port-level checks bound to the fail-safe clock monitor
`timescale 1ns/10ps
`default_nettype none
module fsm_properties
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       pri_osc_in,
  input wire logic       sec_osc_in,
  input wire logic       internal_osc_block_in,
  input wire logic [2:0] primary_mode,
  input wire logic [1:0] clock_select_register,
  input wire logic       monitor_enable_bit,
  input wire logic       osc_fail_ie,
  input wire logic       osc_fail_flag_clr,
  input wire logic       pm_enter,
  input wire logic       sleep_enter,
  input wire logic       wake,
  input wire logic       idle_mode,
  input wire logic       irq_pending,
  input wire logic       dev_clk_out,
  input wire logic [1:0] active_src,
  input wire logic       primary_osc_enable,
  input wire logic       primary_clock_ready_status,
  input wire logic       osc_fail_flag,
  input wire logic       fail_safe_active,
  input wire logic       wdt_reset,
  input wire logic       cpu_resume
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Watchdog restart lasts exactly one cycle
  sequence wdt_pulse;
    wdt_reset ##1 !wdt_reset;
  endsequence

  a_fail_wdt_pulse: assert property ($rose(fail_safe_active) |-> osc_fail_flag ##0 wdt_pulse)
    else $error("fail-safe entry without flag or single watchdog pulse");
  a_wdt_cause: assert property (wdt_reset |-> $rose(fail_safe_active))
    else $error("watchdog restart without a new failure");
  a_fail_to_int: assert property ($rose(fail_safe_active) |-> ##[0:600] active_src == 2'h2)
    else $error("device clock not moved to internal source after failure");
  a_no_return: assert property (fail_safe_active && active_src == 2'h2 && !pm_enter
    |=> active_src == 2'h2) else $error("device clock left internal source during fail-safe");
  a_flag_sticky: assert property (osc_fail_flag && !osc_fail_flag_clr |=> osc_fail_flag)
    else $error("failure flag dropped without a clear");
  a_safe_exit: assert property ($fell(fail_safe_active) |-> $past(pm_enter))
    else $error("fail-safe ended without mode entry or reset");
  a_no_bridge_fail: assert property ($rose(osc_fail_flag) |-> $past(active_src) != 2'h2)
    else $error("failure flagged while running on internal source");
  a_ready_switch: assert property ($rose(primary_clock_ready_status)
    |-> ##[0:600] active_src == 2'h0) else $error("ready primary not driving the device clock");
  a_pm_select: assert property (pm_enter && clock_select_register == 2'h1
    |-> ##[1:600] active_src == 2'h1) else $error("mode entry ignored the selected source");
  a_pm_pri_off: assert property (pm_enter && !primary_clock_ready_status && !fail_safe_active
    && clock_select_register != 2'h0 |-> ##[1:2] !primary_osc_enable)
    else $error("primary left enabled after mode change during start-up");
  a_idle_resume: assert property (idle_mode && irq_pending && !osc_fail_ie |=> cpu_resume)
    else $error("idle interrupt did not resume execution");
endmodule : fsm_properties

bind fail_safe_monitor fsm_properties fsm_properties_i (.*);
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the fail-safe clock monitor
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic       clk;
  logic       sys_rst;
  logic       pri_run;
  logic       pri_osc_in;
  logic       sec_osc_in;
  logic       internal_osc_block_in;
  logic [2:0] primary_mode;
  logic [1:0] clock_select_register;
  logic       monitor_enable_bit;
  logic       osc_fail_ie;
  logic       osc_fail_flag_clr;
  logic       pm_enter;
  logic       sleep_enter;
  logic       wake;
  logic       idle_mode;
  logic       irq_pending;
  logic       dev_clk_out;
  logic [1:0] active_src;
  logic       primary_osc_enable;
  logic       primary_clock_ready_status;
  logic       osc_fail_flag;
  logic       fail_safe_active;
  logic       wdt_reset;
  logic       cpu_resume;
  int         err_count;
  int         samples_checked;

  // Crystal only swings while the device enables it
  osc_model #(.HALF_NS(40)) pri_osc_i (.run(pri_run & primary_osc_enable), .osc(pri_osc_in));
  osc_model #(.HALF_NS(55)) sec_osc_i (.run(1'b1), .osc(sec_osc_in));
  osc_model #(.HALF_NS(25)) int_osc_i (.run(1'b1), .osc(internal_osc_block_in));
  fail_safe_monitor fail_safe_monitor_i
  (
    .clk                        (clk),
    .sys_rst                    (sys_rst),
    .pri_osc_in                 (pri_osc_in),
    .sec_osc_in                 (sec_osc_in),
    .internal_osc_block_in      (internal_osc_block_in),
    .primary_mode               (primary_mode),
    .clock_select_register      (clock_select_register),
    .monitor_enable_bit         (monitor_enable_bit),
    .osc_fail_ie                (osc_fail_ie),
    .osc_fail_flag_clr          (osc_fail_flag_clr),
    .pm_enter                   (pm_enter),
    .sleep_enter                (sleep_enter),
    .wake                       (wake),
    .idle_mode                  (idle_mode),
    .irq_pending                (irq_pending),
    .dev_clk_out                (dev_clk_out),
    .active_src                 (active_src),
    .primary_osc_enable         (primary_osc_enable),
    .primary_clock_ready_status (primary_clock_ready_status),
    .osc_fail_flag              (osc_fail_flag),
    .fail_safe_active           (fail_safe_active),
    .wdt_reset                  (wdt_reset),
    .cpu_resume                 (cpu_resume)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic check(input string name, input logic [1:0] exp, input logic [1:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check

  // Bounded poll on the falling edge, where registered outputs have settled
  task automatic wait_for(input int sel, input logic [1:0] exp, input int n);
    logic [1:0] v;
    v = 2'h3;
    for (int i = 0; i < n && v !== exp; i++)
    begin
      @(negedge clk);
      v = (sel == 0) ? active_src : {1'b0, (sel == 1) ? osc_fail_flag : primary_clock_ready_status};
    end
    check("wait", exp, v);
    if (v !== exp)
      summarize();
  endtask : wait_for

  task automatic pulse(input int sel);
    @(posedge clk);
    pm_enter <= (sel == 0);
    wake <= (sel == 1);
    osc_fail_flag_clr <= (sel == 2);
    sleep_enter <= (sel == 3);
    @(posedge clk);
    pm_enter <= 1'b0;
    wake <= 1'b0;
    osc_fail_flag_clr <= 1'b0;
    sleep_enter <= 1'b0;
  endtask : pulse

  task automatic do_reset(input logic [2:0] mode);
    @(posedge clk);
    sys_rst <= 1'b1;
    primary_mode <= mode;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("reset src", fail_safe_monitor_pkg::SEL_INTERNAL, active_src);
    check("reset state", 2'h2, {primary_osc_enable, osc_fail_flag | primary_clock_ready_status});
    @(posedge clk);
    sys_rst <= 1'b0;
  endtask : do_reset

  task automatic set_in(input logic run, input logic [1:0] sel);
    @(posedge clk);
    pri_run <= run;
    clock_select_register <= sel;
  endtask : set_in

  initial
  begin
    sys_rst = 1'b1;
    pri_run = 1'b1;
    primary_mode = fail_safe_monitor_pkg::ext_clock_mode;
    clock_select_register = fail_safe_monitor_pkg::SEL_PRIMARY;
    monitor_enable_bit = 1'b1;
    osc_fail_ie = 1'b1;
    osc_fail_flag_clr = 1'b0;
    pm_enter = 1'b0;
    sleep_enter = 1'b0;
    wake = 1'b0;
    idle_mode = 1'b0;
    irq_pending = 1'b0;
    err_count = 0;
    samples_checked = 0;
    // External clock and RC modes run the primary straight after power-on
    for (int m = 0; m < 3; m++)
    begin
      do_reset(3'(m));
      wait_for(2, 2'h1, 2000);
      wait_for(0, fail_safe_monitor_pkg::SEL_PRIMARY, 600);
    end
    // Sleep parks the device on the internal source, wake resumes primary
    pulse(3);
    wait_for(0, fail_safe_monitor_pkg::SEL_INTERNAL, 600);
    pulse(1);
    wait_for(2, 2'h1, 2000);
    $display("test direct start done");
    // Primary dies; sample clock is slow, so the wait is long by nature
    set_in(1'b0, fail_safe_monitor_pkg::SEL_PRIMARY);
    wait_for(1, 2'h1, 30000);
    check("fail-safe", 2'h1, {1'b0, fail_safe_active});
    wait_for(0, fail_safe_monitor_pkg::SEL_INTERNAL, 600);
    set_in(1'b1, fail_safe_monitor_pkg::SEL_PRIMARY);
    repeat (3000) @(posedge clk);
    @(negedge clk);
    check("no return", fail_safe_monitor_pkg::SEL_INTERNAL, active_src);
    pulse(2);
    @(negedge clk);
    check("flag clear", 2'h0, {1'b0, osc_fail_flag});
    set_in(1'b1, fail_safe_monitor_pkg::SEL_SECONDARY);
    pulse(0);
    wait_for(0, fail_safe_monitor_pkg::SEL_SECONDARY, 600);
    check("fail-safe exit", 2'h0, {1'b0, fail_safe_active});
    $display("test failure done");
    @(posedge clk);
    osc_fail_ie <= 1'b0;
    idle_mode <= 1'b1;
    irq_pending <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("resume", 2'h1, {1'b0, cpu_resume});
    @(posedge clk);
    osc_fail_ie <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("no resume", 2'h0, {1'b0, cpu_resume});
    @(posedge clk);
    idle_mode <= 1'b0;
    $display("test idle done");
    // Crystal that never starts stays bridged and unflagged
    set_in(1'b0, fail_safe_monitor_pkg::SEL_PRIMARY);
    do_reset(fail_safe_monitor_pkg::crystal_mode);
    repeat (5000) @(posedge clk);
    @(negedge clk);
    check("bridge src", fail_safe_monitor_pkg::SEL_INTERNAL, active_src);
    check("bridge flags", 2'h0, {primary_clock_ready_status, osc_fail_flag});
    set_in(1'b0, fail_safe_monitor_pkg::SEL_SECONDARY);
    pulse(0);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("pri disabled", 2'h0, {1'b0, primary_osc_enable});
    $display("test bridge done");
    // Each crystal mode waits out the start-up timer, then takes over
    for (int m = 3; m < 7; m++)
    begin
      set_in(1'b1, fail_safe_monitor_pkg::SEL_PRIMARY);
      do_reset(3'(m));
      repeat (4000) @(posedge clk);
      @(negedge clk);
      check("early ready", 2'h0, {1'b0, primary_clock_ready_status});
      wait_for(2, 2'h1, 40000);
      wait_for(0, fail_safe_monitor_pkg::SEL_PRIMARY, 600);
    end
    $display("test crystal start done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
